// ===== uart_ctl.sv
// serial channel interrupt, preload and modem port control
//
// Behaviour
// - receiver status flag shows fifo full or receiver ready per mode bit 6
// - transmitter ready is one when holding empty, zero after load or disable
// - character written while transmitter ready is zero is dropped
// - interrupt asserted when any status flag and its mask bit are set
// - status read shows true flags whatever the mask holds
// - mask bits 7,2,1,0 enable sources; write-only; reset zero
// - preload is high byte then low byte of a sixteen-bit value
// - both preload bytes are write-only, reads give zero
// - eight-bit vector register resets to 0f hex
// - input port bit gives clear-to-send level latched at the read
// - input port bit equals change register bit 0
// - one written to set address asserts request-to-send
// - one written to clear address negates request-to-send
// - request-to-send pin is the inverse of the internal bit
// - reading the change register clears the change-of-state flag
// - status bit 7 set by a transition only when input enable is one
// - delta break set on start or end of a received break
`timescale 1ns/1ps
module uart_ctl
  import uart_ctl_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire uart_ctl_pkg::bus_req_t bus_req,
  output logic [7:0]                  rdata,
  input  wire uart_ctl_pkg::rx_stat_t rx_stat,
  input  wire logic                   mode_ff_sel,
  input  wire logic                   cts_n_pin,
  input  wire logic                   tx_shift_take,
  output logic                        rts_n_pin,
  output logic                        irq,
  output logic [7:0]                  vector,
  output logic [15:0]                 preload,
  output logic                        tx_load,
  output logic [7:0]                  tx_char
);
  import uart_ctl_pkg::*;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] mask_reg;
  logic [7:0] preload_hi_reg;
  logic [7:0] preload_lo_reg;
  logic       rts_bit_reg;
  logic       iec_reg;
  logic       tx_en_reg;
  logic       tx_full_reg;
  logic       cts_s;
  logic       cts_prev_reg;
  logic       cos_chg;
  logic       cos_isr;
  logic       dbrk;
  logic [7:0] status;
  logic       wr;
  logic       rd;

  assign wr = bus_req.wr;
  assign rd = bus_req.rd;

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  sync2 u_cts
  (
    .clock   (clock),
    .reset_n (reset_n),
    .d       (cts_n_pin),
    .q       (cts_s)
  );

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      cts_prev_reg <= 1'b1;
    else
      cts_prev_reg <= cts_s;
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      mask_reg <= RST_MASK;
    else if (wr && bus_req.addr == OFF_STATUS_MASK)
      mask_reg <= bus_req.wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      preload_hi_reg <= RST_PRELOAD;
      preload_lo_reg <= RST_PRELOAD;
    end
    else if (wr && bus_req.addr == OFF_PRELOAD_HI)
      preload_hi_reg <= bus_req.wdata;
    else if (wr && bus_req.addr == OFF_PRELOAD_LO)
      preload_lo_reg <= bus_req.wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      preload <= {RST_PRELOAD, RST_PRELOAD};
    else
      preload <= {preload_hi_reg, preload_lo_reg};
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      vector <= RST_VECTOR;
    else if (wr && bus_req.addr == OFF_VECTOR)
      vector <= bus_req.wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      iec_reg   <= 1'b0;
      tx_en_reg <= 1'b0;
    end
    else if (wr && bus_req.addr == OFF_CONTROL)
    begin
      iec_reg   <= bus_req.wdata[BIT_IEC];
      tx_en_reg <= bus_req.wdata[BIT_TX_EN];
    end
  end

  // ---------------------------------------------------------------
  // request-to-send port
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      rts_bit_reg <= 1'b0;
    else if (wr && bus_req.addr == OFF_RTS_SET && bus_req.wdata[BIT_RTS])
      rts_bit_reg <= 1'b1;
    else if (wr && bus_req.addr == OFF_RTS_CLEAR
             && bus_req.wdata[BIT_RTS])
      rts_bit_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      rts_n_pin <= 1'b1;
    else
      rts_n_pin <= ~rts_bit_reg;
  end

  // ---------------------------------------------------------------
  // transmit holding register
  // ---------------------------------------------------------------
  // a write while full or disabled is dropped, not queued
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      tx_full_reg <= 1'b0;
      tx_char     <= 8'h00;
    end
    else if (!tx_en_reg)
      tx_full_reg <= 1'b0;
    else if (wr && bus_req.addr == OFF_TX_HOLD && !tx_full_reg)
    begin
      tx_full_reg <= 1'b1;
      tx_char     <= bus_req.wdata;
    end
    else if (tx_shift_take)
      tx_full_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      tx_load <= 1'b0;
    else
      tx_load <= tx_en_reg && tx_full_reg && tx_shift_take;
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  status_flag u_cos_chg
  (
    .clock   (clock),
    .reset_n (reset_n),
    .set     (cts_s != cts_prev_reg),
    .clear   (rd && bus_req.addr == OFF_CHANGE),
    .flag    (cos_chg)
  );

  status_flag u_cos_isr
  (
    .clock   (clock),
    .reset_n (reset_n),
    .set     ((cts_s != cts_prev_reg) && iec_reg),
    .clear   (rd && bus_req.addr == OFF_CHANGE),
    .flag    (cos_isr)
  );

  status_flag u_dbrk
  (
    .clock   (clock),
    .reset_n (reset_n),
    .set     (rx_stat.break_edge),
    .clear   (wr && bus_req.addr == OFF_CONTROL
              && bus_req.wdata[BIT_DBRK]),
    .flag    (dbrk)
  );

  always_comb
  begin
    status = 8'h00;
    status[BIT_COS]  = cos_isr;
    status[BIT_DBRK] = dbrk;
    status[BIT_RXF]  = mode_ff_sel ? rx_stat.fifo_full
                                   : rx_stat.rx_ready;
    status[BIT_TXR]  = tx_en_reg && !tx_full_reg;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(status & mask_reg);
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // status and mask share an offset: read gives status, write sets mask
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      unique case (bus_req.addr)
        OFF_STATUS_MASK: rdata <= status;
        OFF_VECTOR:      rdata <= vector;
        OFF_INPUT_PIN:   rdata <= {7'h00, cts_s};
        OFF_CHANGE:      rdata <= {3'h0, cos_chg, CHANGE_ONES[3:1],
                                   cts_s};
        default:         rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_irq_follows;
    @(posedge clock) disable iff (!reset_n)
      1'b1 |=> irq == $past(|(status & mask_reg));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt does not follow masked status");

  property p_mask_reset;
    @(posedge clock) !reset_n |=> mask_reg == 8'h00;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not cleared by reset");

  property p_vec_reset;
    @(posedge clock) !reset_n |=> vector == 8'h0f;
  endproperty
  a_vec_reset: assert property (p_vec_reset)
    else $error("vector reset value wrong");

  property p_rts_set;
    @(posedge clock) disable iff (!reset_n)
      (wr && bus_req.addr == OFF_RTS_SET && bus_req.wdata[0])
        |=> ##1 !rts_n_pin;
  endproperty
  a_rts_set: assert property (p_rts_set)
    else $error("set write did not assert pin");

  property p_rts_clr;
    @(posedge clock) disable iff (!reset_n)
      (wr && bus_req.addr == OFF_RTS_CLEAR && bus_req.wdata[0]
       && !(bus_req.addr == OFF_RTS_SET)) |=> ##1 rts_n_pin;
  endproperty
  a_rts_clr: assert property (p_rts_clr)
    else $error("clear write did not negate pin");

  property p_preload_read;
    @(posedge clock) disable iff (!reset_n)
      (rd && (bus_req.addr == OFF_PRELOAD_HI
              || bus_req.addr == OFF_PRELOAD_LO)) |=> rdata == 8'h00;
  endproperty
  a_preload_read: assert property (p_preload_read)
    else $error("preload value visible on read");

  property p_cos_clear;
    @(posedge clock) disable iff (!reset_n)
      (rd && bus_req.addr == OFF_CHANGE && cts_s == cts_prev_reg)
        |=> !cos_isr;
  endproperty
  a_cos_clear: assert property (p_cos_clear)
    else $error("change read did not clear flag");

  property p_cos_gate;
    @(posedge clock) disable iff (!reset_n)
      (!cos_isr && !iec_reg) |=> !cos_isr;
  endproperty
  a_cos_gate: assert property (p_cos_gate)
    else $error("flag set with input enable off");

  property p_txr_load;
    @(posedge clock) disable iff (!reset_n)
      (wr && bus_req.addr == OFF_TX_HOLD && status[0]) |=> !status[0];
  endproperty
  a_txr_load: assert property (p_txr_load)
    else $error("ready flag still set after load");

  property p_rx_sel;
    @(posedge clock) disable iff (!reset_n)
      status[1] == (mode_ff_sel ? rx_stat.fifo_full : rx_stat.rx_ready);
  endproperty
  a_rx_sel: assert property (p_rx_sel)
    else $error("receiver flag source wrong");

endmodule

// ===== uart_ctl_pkg.sv
// shared constants and types for the serial channel control block
package uart_ctl_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [9:0] OFF_STATUS_MASK = 10'h194;
  localparam logic [9:0] OFF_PRELOAD_HI  = 10'h198;
  localparam logic [9:0] OFF_PRELOAD_LO  = 10'h19c;
  localparam logic [9:0] OFF_VECTOR      = 10'h1f0;
  localparam logic [9:0] OFF_INPUT_PIN   = 10'h1f4;
  localparam logic [9:0] OFF_CHANGE      = 10'h190;
  localparam logic [9:0] OFF_RTS_SET     = 10'h1f8;
  localparam logic [9:0] OFF_RTS_CLEAR   = 10'h1fc;
  localparam logic [9:0] OFF_CONTROL     = 10'h188;
  localparam logic [9:0] OFF_TX_HOLD     = 10'h18c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_COS      = 7;
  localparam int BIT_DBRK     = 2;
  localparam int BIT_RXF      = 1;
  localparam int BIT_TXR      = 0;
  localparam int BIT_FF_SEL   = 6;
  localparam int BIT_IEC      = 0;
  localparam int BIT_CTS      = 0;
  localparam int BIT_RTS      = 0;
  localparam int BIT_CHG_COS  = 4;
  localparam int BIT_TX_EN    = 0;

  // ---------------------------------------------------------------
  // reset values, change register ones and minimum preload
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_VECTOR  = 8'h0f;
  localparam logic [7:0] RST_PRELOAD = 8'h00;
  localparam logic [7:0] CHANGE_ONES = 8'h0e;
  localparam logic [15:0] MIN_PRELOAD = 16'h0002;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic fifo_full;
    logic rx_ready;
    logic tx_empty;
    logic break_edge;
  } rx_stat_t;

endpackage

// ===== sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      meta_reg <= 1'b1;
      q        <= 1'b1;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ===== status_flag.sv
// sticky flag, set beats clear
`timescale 1ns/1ps
module status_flag
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clear)
      flag <= 1'b0;
  end
endmodule

// ===== cpu_master.sv
// processor bus master model driving the register strobes
`timescale 1ns/1ps
module cpu_master
  import uart_ctl_pkg::*;
(
  input  wire logic             clock,
  input  wire logic [7:0]       rdata,
  output uart_ctl_pkg::bus_req_t bus_req
);
  // -------------------------------------------------------
  // strobes
  // -------------------------------------------------------
  initial bus_req = '0;
  // launched at the falling edge, held for one rising edge
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge clock);
    bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(negedge clock);
    bus_req.wr = 1'b0;
  endtask
  // rdata holds until the next read, so it is taken late
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(negedge clock);
    bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock);
    bus_req.rd = 1'b0;
    @(negedge clock);
    v = rdata;
  endtask
  // -------------------------------------------------------
  // start-up
  // -------------------------------------------------------
  task automatic init(input logic [7:0] vec, input logic [15:0] pre);
    logic [15:0] p;
    p = (pre < MIN_PRELOAD) ? MIN_PRELOAD : pre;
    wr(OFF_CONTROL, 8'h00);
    wr(OFF_VECTOR, vec);
    wr(OFF_STATUS_MASK, 8'h00);
    wr(OFF_PRELOAD_HI, p[15:8]);
    wr(OFF_PRELOAD_LO, p[7:0]);
  endtask
endmodule

// ===== uart_interrupt_and_port_control_tb_top.sv
// self-checking bench for the serial channel control block
`timescale 1ns/1ps
module uart_interrupt_and_port_control_tb_top;
  import uart_ctl_pkg::*;
  typedef struct packed {
    logic [7:0] mask;
    logic       ff;
    logic       rr;
    logic       sel;
    logic [7:0] stat;
    logic       irq;
  } row_t;
  // -------------------------------------------------------
  // signals
  // -------------------------------------------------------
  logic        clock;
  logic        reset_n;
  logic        mode_ff_sel;
  logic        cts_n_pin;
  logic        tx_shift_take;
  rx_stat_t    rx_stat;
  bus_req_t    bus_req;
  logic [7:0]  rdata;
  logic [7:0]  vector;
  logic [7:0]  tx_char;
  logic [7:0]  d;
  logic [15:0] preload;
  logic        rts_n_pin;
  logic        irq;
  logic        tx_load;
  int          fails;
  int          samples_checked;
  int          cycles;
  int          i;
  int          n;
  // tx disabled here, so status bit 0 stays low
  localparam row_t ROWS [6] = '{
    '{8'h02, 1'b1, 1'b0, 1'b1, 8'h02, 1'b1},
    '{8'h02, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0},
    '{8'h02, 1'b0, 1'b1, 1'b0, 8'h02, 1'b1},
    '{8'h00, 1'b1, 1'b1, 1'b1, 8'h02, 1'b0},
    '{8'hfd, 1'b1, 1'b1, 1'b1, 8'h02, 1'b0},
    '{8'h01, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0}};
  logic [9:0]  ra [4] = '{OFF_RTS_SET, OFF_RTS_SET, OFF_RTS_CLEAR,
                          OFF_RTS_CLEAR};
  logic [7:0]  rw [4] = '{8'hfe, 8'h01, 8'hfe, 8'h01};
  logic [3:0]  rx = 4'b1001;

  uart_ctl dut (.clock(clock), .reset_n(reset_n), .bus_req(bus_req),
    .rdata(rdata), .rx_stat(rx_stat), .mode_ff_sel(mode_ff_sel),
    .cts_n_pin(cts_n_pin), .tx_shift_take(tx_shift_take),
    .rts_n_pin(rts_n_pin), .irq(irq), .vector(vector),
    .preload(preload), .tx_load(tx_load), .tx_char(tx_char));
  cpu_master m (.clock(clock), .rdata(rdata), .bus_req(bus_req));

  // -------------------------------------------------------
  // helpers
  // -------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string w, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // whole run is about two hundred cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic st;
    m.rd(OFF_STATUS_MASK, d);
  endtask

  // -------------------------------------------------------
  // sequence
  // -------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    mode_ff_sel = 1'b0;
    cts_n_pin = 1'b1;
    tx_shift_take = 1'b0;
    rx_stat = '0;
    repeat (16) @(negedge clock);
    chk("irq", 0, irq);
    chk("rts_n_pin", 1, rts_n_pin);
    chk("vector", 8'h0f, vector);
    chk("preload", 0, preload);
    chk("tx_load", 0, tx_load);
    reset_n = 1'b1;
    m.rd(OFF_VECTOR, d);
    chk("vector_read", 8'h0f, d);
    m.rd(OFF_CHANGE, d);
    m.init(8'h40, 16'h1234);
    repeat (2) @(negedge clock);
    chk("vector", 8'h40, vector);
    chk("preload", 16'h1234, preload);
    m.rd(OFF_PRELOAD_HI, d);
    chk("preload_hi_read", 8'h00, d);
    m.rd(OFF_PRELOAD_LO, d);
    chk("preload_lo_read", 8'h00, d);
    for (i = 0; i < 6; i++)
    begin
      m.wr(OFF_STATUS_MASK, ROWS[i].mask);
      rx_stat.fifo_full = ROWS[i].ff;
      rx_stat.rx_ready = ROWS[i].rr;
      mode_ff_sel = ROWS[i].sel;
      repeat (3) @(negedge clock);
      st();
      chk("status", ROWS[i].stat, d);
      chk("irq", ROWS[i].irq, irq);
    end
    rx_stat = '0;
    for (i = 0; i < 4; i++)
    begin
      m.wr(ra[i], rw[i]);
      repeat (2) @(negedge clock);
      chk("rts_n_pin", rx[i], rts_n_pin);
    end
    // transmit path: second character arrives while full
    m.wr(OFF_STATUS_MASK, 8'h01);
    m.wr(OFF_CONTROL, 8'h01);
    st();
    chk("tx_ready", 1, d[BIT_TXR]);
    chk("irq", 1, irq);
    m.wr(OFF_TX_HOLD, 8'h5a);
    m.wr(OFF_TX_HOLD, 8'ha5);
    st();
    chk("tx_ready", 0, d[BIT_TXR]);
    chk("irq", 0, irq);
    tx_shift_take = 1'b1;
    n = 0;
    while (tx_load !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    chk("tx_load", 1, tx_load);
    chk("tx_char", 8'h5a, tx_char);
    n = 0;
    repeat (10)
    begin
      @(negedge clock);
      if (tx_load === 1'b1)
        n++;
    end
    chk("extra_loads", 0, n[15:0]);
    st();
    chk("tx_ready", 1, d[BIT_TXR]);
    tx_shift_take = 1'b0;
    m.wr(OFF_CONTROL, 8'h00);
    st();
    chk("tx_ready", 0, d[BIT_TXR]);
    // clear-to-send change with input enable on, then off
    m.wr(OFF_CONTROL, 8'h01);
    m.wr(OFF_STATUS_MASK, 8'h80);
    cts_n_pin = 1'b0;
    repeat (6) @(negedge clock);
    st();
    chk("cos_status", 1, d[BIT_COS]);
    chk("irq", 1, irq);
    m.rd(OFF_INPUT_PIN, d);
    chk("cts_level", 0, d[BIT_CTS]);
    m.rd(OFF_CHANGE, d);
    chk("change", 8'h1e, d);
    st();
    chk("cos_status", 0, d[BIT_COS]);
    chk("irq", 0, irq);
    m.wr(OFF_CONTROL, 8'h00);
    cts_n_pin = 1'b1;
    repeat (6) @(negedge clock);
    st();
    chk("cos_status", 0, d[BIT_COS]);
    m.rd(OFF_INPUT_PIN, d);
    chk("cts_level", 1, d[BIT_CTS]);
    m.rd(OFF_CHANGE, d);
    chk("change", 8'h1f, d);
    // break edge, then its clear command
    m.wr(OFF_STATUS_MASK, 8'h04);
    rx_stat.break_edge = 1'b1;
    @(negedge clock);
    rx_stat.break_edge = 1'b0;
    st();
    chk("break_status", 1, d[BIT_DBRK]);
    chk("irq", 1, irq);
    m.wr(OFF_CONTROL, 8'h04);
    st();
    chk("break_status", 0, d[BIT_DBRK]);
    // second reset in mid-run
    m.wr(OFF_RTS_SET, 8'h01);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    chk("rts_n_pin", 1, rts_n_pin);
    chk("vector", 8'h0f, vector);
    chk("preload", 0, preload);
    chk("irq", 0, irq);
    reset_n = 1'b1;
    // mask must be back to zero, so a live receiver flag raises no irq
    rx_stat.rx_ready = 1'b1;
    repeat (2) @(negedge clock);
    chk("rts_n_pin", 1, rts_n_pin);
    chk("irq", 0, irq);
    st();
    chk("status", 8'h02, d);
    m.rd(OFF_VECTOR, d);
    chk("vector_read", 8'h0f, d);
    test_done();
  end
endmodule
